//--- sdr_status_misc.v
// Purpose: pll lock status, link digital hold, analog selects and offset update block
// Assumes: lock inputs are asynchronous; offsets and release pulses come from clk logic
// Notes: offset outputs are the values handed on toward the converter clock domain
`timescale 1ns/1ns
`include "sdr_regs.vh"

module sdr_status_misc (
    input wire clk,                                      // register clock, 125 MHz
    input wire rst_b,                                    // synchronous chip reset, active low
    input wire spi_sclk,                                 // serial clock pin
    input wire spi_cs_b,                                 // chip select pin, active low
    input wire spi_sdi,                                  // serial data in pin
    output wire spi_sdo,                                 // serial data out
    output wire spi_sdo_oe,                              // sdo drive enable
    input wire [3:0] lane_pll_lock_live_in,              // lock of the four lane plls
    output wire link_digital_hold,                       // holds link digital logic in reset
    output wire external_reference_select,               // use external reference
    output wire output_current_double,                   // double output current
    input wire link_enable,                              // link enable from datapath control
    input wire eb_release_attempt,                       // elastic buffer release try, pulse
    input wire [`SDR_ARRIVAL_W-1:0] lane_arrival_in,     // arrival value at release
    output reg [`SDR_ARRIVAL_W-1:0] lane_arrival_value,  // captured arrival value
    output reg lane_arrival_valid,                       // capture has happened
    output wire link_digital_run,                        // link digital logic may run
    input wire [`SDR_OFFSET_W-1:0] converter_offset_value_a, // pending offset, converter a
    input wire [`SDR_OFFSET_W-1:0] converter_offset_value_b, // pending offset, converter b
    output reg [`SDR_OFFSET_W-1:0] applied_offset_a,     // offset in use, converter a
    output reg [`SDR_OFFSET_W-1:0] applied_offset_b      // offset in use, converter b
);

// ----------------------------------------------------------------
// bus and state
// ----------------------------------------------------------------
wire [`SDR_ADDR_W-1:0] reg_addr;
wire [7:0] reg_wdata;
wire reg_wr;
wire reg_rd;
reg [7:0] reg_rdata;
reg [1:0] lock_sync [0:3];
wire [3:0] lock_live;
reg [3:0] lock_lost;
reg [3:0] next_lock_lost;
reg [1:0] lock_armed;
reg [7:0] hold_ctrl;
reg [7:0] ext_ref_ctrl;
reg [7:0] cur_double_ctrl;
reg [7:0] ofs_block_ctrl;
integer i;

// address match used by every write decode
// kept as a function so every write decode compares the same way
function is_wr;
    input [`SDR_ADDR_W-1:0] addr;
    input [`SDR_ADDR_W-1:0] ofs;
    input wr;
    begin
        is_wr = wr && (addr == ofs);
    end
endfunction

// the serial slave owns all pin timing; this module only sees strobes
sdr_spi u_spi (
    .clk(clk),
    .rst_b(rst_b),
    .spi_sclk(spi_sclk),
    .spi_cs_b(spi_cs_b),
    .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
);

// ----------------------------------------------------------------
// lock status
// ----------------------------------------------------------------
// lock comes from the pll macros on their own clocks, so two stages each;
// lock_armed marks when both stages hold real pin values after reset
always @(posedge clk) begin
    if (!rst_b) begin
        lock_armed <= 2'h0;
        for (i = 0; i < `SDR_NUM_PLL; i = i + 1) begin
            lock_sync[i] <= 2'h0;
        end
    end else begin
        lock_armed <= {lock_armed[0], 1'b1};
        for (i = 0; i < `SDR_NUM_PLL; i = i + 1) begin
            lock_sync[i] <= {lock_sync[i][0], lane_pll_lock_live_in[i]};
        end
    end
end

// live bits lag the macros by two clk; a dropout shorter than one clk
// can slip between samples and is then not flagged
// bit n belongs to the pll of lanes 4n to 4n+3
assign lock_live = {lock_sync[3][1], lock_sync[2][1], lock_sync[1][1], lock_sync[0][1]};

// ----------------------------------------------------------------
// lock lost flags
// ----------------------------------------------------------------
// clear first, then set, so a low lock in the clearing cycle survives
// write-one-to-clear touches bits 3:0 only; the live nibble ignores writes
always @* begin
    next_lock_lost = lock_lost;
    if (is_wr(reg_addr, `SDR_OFS_PLL_LOCK_STATE, reg_wr)) begin
        next_lock_lost = lock_lost & ~reg_wdata[`SDR_LOST_LSB+3:`SDR_LOST_LSB];
    end
    // the reset value of the stages reads as lock loss, so wait until they fill
    if (lock_armed[1]) begin
        next_lock_lost = next_lock_lost | ~lock_live;
    end
end

// lost bits start clear; only a real low lock after reset can set them
always @(posedge clk) begin
    if (!rst_b) begin
        lock_lost <= `SDR_LOST_RESET;
    end else begin
        lock_lost <= next_lock_lost;
    end
end

// ----------------------------------------------------------------
// control registers
// ----------------------------------------------------------------
// reserved bits are kept as plain storage and read back as written
// one offset matches per strobe, so the else-if chain drops nothing
always @(posedge clk) begin
    if (!rst_b) begin
        hold_ctrl <= `SDR_CTRL_RESET;
        ext_ref_ctrl <= `SDR_CTRL_RESET;
        cur_double_ctrl <= `SDR_CTRL_RESET;
        ofs_block_ctrl <= `SDR_CTRL_RESET;
    end else if (is_wr(reg_addr, `SDR_OFS_LINK_HOLD, reg_wr)) begin
        hold_ctrl <= reg_wdata;
    end else if (is_wr(reg_addr, `SDR_OFS_EXT_REF, reg_wr)) begin
        ext_ref_ctrl <= reg_wdata;
    end else if (is_wr(reg_addr, `SDR_OFS_CUR_DOUBLE, reg_wr)) begin
        cur_double_ctrl <= reg_wdata;
    end else if (is_wr(reg_addr, `SDR_OFS_OFFSET_BLOCK, reg_wr)) begin
        ofs_block_ctrl <= reg_wdata;
    end
end

// hold acts on the digital link only; lane circuitry keeps running
assign link_digital_hold = hold_ctrl[`SDR_CTRL_BIT];
assign external_reference_select = ext_ref_ctrl[`SDR_CTRL_BIT];
assign output_current_double = cur_double_ctrl[`SDR_CTRL_BIT];
// the digital link runs only when enabled and released from hold;
// setting hold before enable keeps it idle while supplies settle
assign link_digital_run = link_enable & ~link_digital_hold;

// ----------------------------------------------------------------
// lane arrival capture
// ----------------------------------------------------------------
// only the first release attempt is kept; hold rearms the capture
// a release while the link is disabled is ignored and keeps the capture armed
always @(posedge clk) begin
    if (!rst_b || link_digital_hold) begin
        lane_arrival_value <= {`SDR_ARRIVAL_W{1'b0}};
        lane_arrival_valid <= 1'b0;
    end else if (link_enable && eb_release_attempt && !lane_arrival_valid) begin
        lane_arrival_value <= lane_arrival_in;
        lane_arrival_valid <= 1'b1;
    end
end

// ----------------------------------------------------------------
// offset update block
// ----------------------------------------------------------------
// there is no fast clock here: the values are handed on in clk, and the
// receiving side must move both words with one common enable
// both outputs share one enable, so a release lands on both in one edge
always @(posedge clk) begin
    if (!rst_b) begin
        applied_offset_a <= {`SDR_OFFSET_W{1'b0}};
        applied_offset_b <= {`SDR_OFFSET_W{1'b0}};
    end else if (!ofs_block_ctrl[`SDR_CTRL_BIT]) begin
        applied_offset_a <= converter_offset_value_a;
        applied_offset_b <= converter_offset_value_b;
    end
end

// ----------------------------------------------------------------
// read mux
// ----------------------------------------------------------------
// combinational mux; the slave latches it one clk after the address
// strobe, so a status read is a snapshot of that cycle
always @* begin
    if (reg_addr == `SDR_OFS_PLL_LOCK_STATE) begin
        reg_rdata = {lock_live, lock_lost};
    end else if (reg_addr == `SDR_OFS_LINK_HOLD) begin
        reg_rdata = hold_ctrl;
    end else if (reg_addr == `SDR_OFS_EXT_REF) begin
        reg_rdata = ext_ref_ctrl;
    end else if (reg_addr == `SDR_OFS_CUR_DOUBLE) begin
        reg_rdata = cur_double_ctrl;
    end else if (reg_addr == `SDR_OFS_OFFSET_BLOCK) begin
        reg_rdata = ofs_block_ctrl;
    end else begin
        reg_rdata = 8'h00;
    end
end

endmodule

//--- sdr_regs.vh
// Purpose: offsets, field positions, reset values and frame sizes of the status/misc bank
// Assumes: 15-bit register address, 8-bit registers, 24-bit serial frame
// Notes: included by both design files
`ifndef SDR_REGS_VH
`define SDR_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SDR_ADDR_W 15
`define SDR_OFS_PLL_LOCK_STATE 15'h0250
`define SDR_OFS_LINK_HOLD 15'h0253
`define SDR_OFS_EXT_REF 15'h02B0
`define SDR_OFS_CUR_DOUBLE 15'h02B1
`define SDR_OFS_OFFSET_BLOCK 15'h02CF

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define SDR_LIVE_LSB 4
`define SDR_LOST_LSB 0
`define SDR_NUM_PLL 4
`define SDR_CTRL_BIT 0
`define SDR_CTRL_RESET 8'h00
`define SDR_LOST_RESET 4'h0

// ----------------------------------------------------------------
// serial frame: read flag, 15 address bits, 8 data bits
// ----------------------------------------------------------------
`define SDR_FRAME_BITS 5'h18
`define SDR_HDR_BITS 5'h10
`define SDR_OFFSET_W 16
`define SDR_ARRIVAL_W 8

`endif

//--- sdr_spi.v
// Purpose: serial control port slave producing register read and write strobes
// Assumes: mode 0, first bit high means read, msb first, frame ends with cs_b high
// Notes: pins are resynchronised to clk, so sclk must be well below clk/4
`timescale 1ns/1ns
`include "sdr_regs.vh"

module sdr_spi (
    input wire clk,                          // register clock
    input wire rst_b,                        // synchronous reset, active low
    input wire spi_sclk,                     // serial clock pin
    input wire spi_cs_b,                     // chip select pin, active low
    input wire spi_sdi,                      // serial data in pin
    output reg spi_sdo,                      // serial data out
    output reg spi_sdo_oe,                   // sdo drive enable, high while driving
    output reg [`SDR_ADDR_W-1:0] reg_addr,   // register address
    output reg [7:0] reg_wdata,              // write data
    output reg reg_wr,                       // write strobe, one cycle
    output reg reg_rd,                       // read strobe, one cycle
    input wire [7:0] reg_rdata               // read data, valid with reg_rd
);

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
reg [2:0] sclk_sync;
reg [1:0] cs_sync;
reg [1:0] sdi_sync;
reg [4:0] bit_cnt;
reg [23:0] shift_in;
reg [7:0] shift_out;
reg is_read;
wire sclk_rise;
wire sclk_fall;
wire [23:0] next_shift;

// the third sclk stage only feeds the edge detector, never the first
always @(posedge clk) begin
    if (!rst_b) begin
        sclk_sync <= 3'h0;
        cs_sync <= 2'h3;
        sdi_sync <= 2'h0;
    end else begin
        sclk_sync <= {sclk_sync[1:0], spi_sclk};
        cs_sync <= {cs_sync[0], spi_cs_b};
        sdi_sync <= {sdi_sync[0], spi_sdi};
    end
end

assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];
assign next_shift = {shift_in[22:0], sdi_sync[1]};

// ----------------------------------------------------------------
// frame decoder
// ----------------------------------------------------------------
// a frame cut short by cs_b ends with no write strobe; a read strobe fires once its header is in
always @(posedge clk) begin
    if (!rst_b) begin
        bit_cnt <= 5'h00;
        shift_in <= 24'h000000;
        shift_out <= 8'h00;
        is_read <= 1'b0;
        reg_addr <= {`SDR_ADDR_W{1'b0}};
        reg_wdata <= 8'h00;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        spi_sdo <= 1'b0;
        spi_sdo_oe <= 1'b0;
    end else begin
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        if (cs_sync[1]) begin
            bit_cnt <= 5'h00;
            is_read <= 1'b0;
            spi_sdo_oe <= 1'b0;
        end else begin
            if (sclk_rise && bit_cnt < `SDR_FRAME_BITS) begin
                shift_in <= next_shift;
                bit_cnt <= bit_cnt + 5'h01;
                if (bit_cnt == `SDR_HDR_BITS - 5'h01) begin
                    reg_addr <= next_shift[`SDR_ADDR_W-1:0];
                    is_read <= next_shift[15];
                    reg_rd <= next_shift[15];
                end
                if (bit_cnt == `SDR_FRAME_BITS - 5'h01 && !is_read) begin
                    reg_wdata <= next_shift[7:0];
                    reg_wr <= 1'b1;
                end
            end
            // read data is latched the cycle after the header completes
            if (reg_rd) begin
                shift_out <= reg_rdata;
            end
            // present data bits after each falling edge of the data phase
            if (sclk_fall && is_read && bit_cnt >= `SDR_HDR_BITS
                    && bit_cnt < `SDR_FRAME_BITS) begin
                spi_sdo <= shift_out[7];
                shift_out <= {shift_out[6:0], 1'b0};
                spi_sdo_oe <= 1'b1;
            end
        end
    end
end

endmodule

//--- sdr_status_misc_chk.sv
// Purpose: port-level assertions for the status and misc register bank
// Assumes: one clock domain, synchronous active-low reset
// Notes: the block bit is internal, so offset checks tie outputs to pending inputs only
`timescale 1ns/1ns
`include "sdr_regs.vh"

module sdr_status_misc_chk (
    input wire clk,                                   // register clock
    input wire rst_b,                                 // reset, active low
    input wire spi_cs_b,                              // chip select
    input wire spi_sdo_oe,                            // sdo enable
    input wire link_digital_hold,                     // hold output
    input wire external_reference_select,             // reference select
    input wire output_current_double,                 // current doubling
    input wire link_enable,                           // link enable
    input wire eb_release_attempt,                    // release try
    input wire [`SDR_ARRIVAL_W-1:0] lane_arrival_in,  // arrival in
    input wire [`SDR_ARRIVAL_W-1:0] lane_arrival_value, // captured arrival
    input wire lane_arrival_valid,                    // capture done
    input wire link_digital_run,                      // run output
    input wire [`SDR_OFFSET_W-1:0] converter_offset_value_a, // pending a
    input wire [`SDR_OFFSET_W-1:0] converter_offset_value_b, // pending b
    input wire [`SDR_OFFSET_W-1:0] applied_offset_a,  // applied a
    input wire [`SDR_OFFSET_W-1:0] applied_offset_b   // applied b
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ----------------------------------------------------------------
    // sequences
    // ----------------------------------------------------------------
    // a capture is only legal once per arm, and never while held
    sequence s_first_release;
        eb_release_attempt && link_enable && !link_digital_hold && !lane_arrival_valid;
    endsequence
    // bus quiet long enough for any write to have landed and sdo to let go
    sequence s_quiet_bus;
        spi_cs_b [*6];
    endsequence

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    chk_run_gating: assert property (link_digital_run == (link_enable && !link_digital_hold))
        else $error("run output does not follow enable and hold");
    chk_hold_clears: assert property (link_digital_hold |=> !lane_arrival_valid)
        else $error("arrival capture survives the hold");
    chk_first_capture: assert property (s_first_release |=>
        lane_arrival_valid && lane_arrival_value == $past(lane_arrival_in))
        else $error("arrival value not captured on first release");
    chk_no_recapture: assert property (lane_arrival_valid && $past(lane_arrival_valid)
        |-> $stable(lane_arrival_value))
        else $error("arrival value recaptured");
    chk_offset_pair: assert property (
        ($changed(applied_offset_a) || $changed(applied_offset_b))
        |-> applied_offset_a == $past(converter_offset_value_a)
        && applied_offset_b == $past(converter_offset_value_b))
        else $error("offsets not applied together");
    chk_ctrl_quiet: assert property (s_quiet_bus |-> $stable(link_digital_hold)
        && $stable(external_reference_select) && $stable(output_current_double))
        else $error("control output moved without a write");
    chk_sdo_release: assert property (s_quiet_bus |-> !spi_sdo_oe)
        else $error("sdo driven with chip select high");
    chk_reset_state: assert property ($rose(rst_b) |-> !link_digital_hold
        && !external_reference_select && !output_current_double && !lane_arrival_valid
        && applied_offset_a == 16'h0000 && applied_offset_b == 16'h0000)
        else $error("outputs not cleared by reset");
endmodule

bind sdr_status_misc sdr_status_misc_chk u_chk (.clk(clk), .rst_b(rst_b), .spi_cs_b(spi_cs_b),
    .spi_sdo_oe(spi_sdo_oe), .link_digital_hold(link_digital_hold),
    .external_reference_select(external_reference_select),
    .output_current_double(output_current_double), .link_enable(link_enable),
    .eb_release_attempt(eb_release_attempt), .lane_arrival_in(lane_arrival_in),
    .lane_arrival_value(lane_arrival_value), .lane_arrival_valid(lane_arrival_valid),
    .link_digital_run(link_digital_run), .converter_offset_value_a(converter_offset_value_a),
    .converter_offset_value_b(converter_offset_value_b), .applied_offset_a(applied_offset_a),
    .applied_offset_b(applied_offset_b));

//--- sdr_status_misc_tb.sv
// Purpose: self-checking bench for the status and misc register bank
// Assumes: serial half period of 6 clk, well clear of the pin synchronisers
// Notes: a small register model predicts every read and control pin
`timescale 1ns/1ns
`include "sdr_regs.vh"

module sdr_status_misc_tb;
    reg clk, rst_b, spi_sclk, spi_cs_b, spi_sdi, link_enable, eb_release_attempt;
    reg [3:0] lock;
    reg [7:0] arr_in, q;
    reg [7:0] m [0:3];
    reg [14:0] ad [0:3];
    reg [15:0] ofs_a, ofs_b, sa, sb;
    reg [31:0] rnd;
    wire spi_sdo, spi_sdo_oe, hold, ext, cur, arr_valid, run;
    wire [7:0] arr;
    wire [15:0] app_a, app_b;
    wire [3:0] pins = {1'b0, cur, ext, hold};
    integer err_total, total_checks, cyc, k, n, lost;

    sdr_status_misc dut (.clk(clk), .rst_b(rst_b), .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b),
        .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
        .lane_pll_lock_live_in(lock), .link_digital_hold(hold), .external_reference_select(ext),
        .output_current_double(cur), .link_enable(link_enable),
        .eb_release_attempt(eb_release_attempt), .lane_arrival_in(arr_in),
        .lane_arrival_value(arr), .lane_arrival_valid(arr_valid), .link_digital_run(run),
        .converter_offset_value_a(ofs_a), .converter_offset_value_b(ofs_b),
        .applied_offset_a(app_a), .applied_offset_b(app_b));

    // ----------------------------------------------------------------
    // clock, timeout and shared tasks
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // the whole run needs about 15000 cycles; a hung frame trips this
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            err_total = err_total + 1;
            conclude;
        end
    end
    task conclude;
        begin
            $display("checks %0d mismatches %0d", total_checks, err_total);
            if (err_total == 0 && total_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task check(input [15:0] seen, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("unexpected at %0t: got %h want %h", $time, seen, exp);
            end
        end
    endtask
    // one whole frame; sdo is taken at the end of each low phase of the data bits
    task spi(input rd, input [14:0] a, input [7:0] d);
        reg [23:0] f;
        integer i;
        begin
            f = {rd, a, d};
            spi_cs_b = 1'b0;
            repeat (6) @(negedge clk);
            for (i = 23; i >= 0; i = i - 1) begin
                spi_sdi = f[i];
                repeat (6) @(negedge clk);
                if (i < 8)
                    q[i] = spi_sdo;
                spi_sclk = 1'b1;
                repeat (6) @(negedge clk);
                spi_sclk = 1'b0;
            end
            repeat (6) @(negedge clk);
            spi_cs_b = 1'b1;
            repeat (6) @(negedge clk);
        end
    endtask
    task rd_status;
        begin
            spi(1'b1, `SDR_OFS_PLL_LOCK_STATE, 8'h00);
            check(q, {lock, lost[3:0]});
        end
    endtask
    task pulse(input [7:0] v);
        begin
            arr_in = v;
            eb_release_attempt = 1'b1;
            @(negedge clk);
            eb_release_attempt = 1'b0;
            arr_in = ~v;
            repeat (2) @(negedge clk);
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst_b, spi_sclk, spi_sdi, link_enable, eb_release_attempt} = 5'h00;
        spi_cs_b = 1'b1;
        lock = 4'hF;
        {arr_in, ofs_a, ofs_b} = 40'h0;
        {err_total, total_checks, cyc} = 0;
        ad[0] = `SDR_OFS_LINK_HOLD;
        ad[1] = `SDR_OFS_EXT_REF;
        ad[2] = `SDR_OFS_CUR_DOUBLE;
        ad[3] = `SDR_OFS_OFFSET_BLOCK;
        lost = 0; // lost bits start clear; reset is no lock loss
        k = $urandom(32'h3222274e);
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        repeat (6) @(negedge clk);
        for (k = 0; k < 4; k = k + 1) begin
            m[k] = `SDR_CTRL_RESET;
            spi(1'b1, ad[k], 8'h00);
            check(q, m[k]);
        end
        rd_status;
        // drop all four plls at once so every lost bit latches
        lock = 4'h0;
        repeat (5) @(negedge clk);
        lock = 4'hF;
        lost = 4'hF;
        repeat (5) @(negedge clk);
        rd_status;
        spi(1'b0, `SDR_OFS_PLL_LOCK_STATE, 8'hF1);
        lost = 4'hE;
        rd_status;
        spi(1'b0, `SDR_OFS_PLL_LOCK_STATE, 8'h00);
        rd_status;
        spi(1'b0, `SDR_OFS_PLL_LOCK_STATE, 8'h0E);
        lost = 0;
        rd_status;
        // drop each pll in turn; the lost bit must outlive the drop
        for (n = 0; n < 4; n = n + 1) begin
            lock[n] = 1'b0;
            lost = lost | (1 << n);
            repeat (5) @(negedge clk);
            rd_status;
            lock[n] = 1'b1;
            repeat (5) @(negedge clk);
            rd_status;
        end
        lock[2] = 1'b0;
        spi(1'b0, `SDR_OFS_PLL_LOCK_STATE, 8'h0F);
        lost = 4'h4;
        rd_status;
        lock[2] = 1'b1;
        repeat (5) @(negedge clk);
        spi(1'b0, `SDR_OFS_PLL_LOCK_STATE, 8'h04);
        lost = 0;
        rd_status;
        // random bytes in every control register, reserved bits kept
        for (n = 0; n < 8; n = n + 1) begin
            k = n % 4;
            rnd = $urandom;
            m[k] = rnd[7:0];
            spi(1'b0, ad[k], m[k]);
            spi(1'b1, ad[k], 8'h00);
            check(q, m[k]);
            if (k < 3)
                check(pins[k], m[k][0]);
        end
        rnd = $urandom;
        spi(1'b0, 15'h0251, rnd[7:0]);
        spi(1'b1, 15'h0251, 8'h00);
        check(q, 8'h00);
        // offsets follow, freeze under the block bit, then land together
        spi(1'b0, ad[3], 8'h00);
        {ofs_a, ofs_b} = $urandom;
        repeat (3) @(negedge clk);
        check(app_a, ofs_a);
        check(app_b, ofs_b);
        spi(1'b0, ad[3], 8'h01);
        sa = ofs_a;
        sb = ofs_b;
        {ofs_a, ofs_b} = $urandom;
        repeat (20) @(negedge clk);
        check(app_a, sa);
        check(app_b, sb);
        spi(1'b0, ad[3], 8'h00);
        check(app_a, ofs_a);
        check(app_b, ofs_b);
        // hold goes up before link enable, as software is told to do
        spi(1'b0, ad[0], 8'h01);
        link_enable = 1'b1;
        check(run, 1'b0);
        pulse(8'h5A);
        check(arr_valid, 1'b0);
        spi(1'b0, ad[0], 8'h00);
        check(run, 1'b1);
        n = $urandom;
        pulse(n[7:0]);
        check(arr_valid, 1'b1);
        check(arr, n[7:0]);
        pulse(~n[7:0]);
        check(arr, n[7:0]);
        conclude;
    end
endmodule
